/* File: fec_erase_ctl.sv */
`timescale 1ns/10ps
`include "fec_params.svh"
module fec_erase_ctl
	import fec_pkg::*;
#(
	parameter int COLLECT_CYC = `FEC_COLLECT_CYC,
	parameter int SETTLE_CYC = `FEC_SETTLE_CYC
)(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	// host byte bus
	input wire logic i_wr_stb,
	input wire logic i_rd_stb,
	input wire logic [11:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic [3:0] i_main_sector_selects,
	input wire logic [1:0] i_secondary_sector_selects,
	input wire logic i_control_io_space,
	// flash array
	input wire logic [7:0] i_array_rdata,
	input wire logic i_array_done,
	input wire logic i_array_fail,
	// protection straps
	input wire logic [3:0] i_main_prot,
	input wire logic [1:0] i_secondary_prot,
	input wire logic i_security_lock,
	// read answer
	output logic [7:0] o_rdata,
	output logic o_rd_vld,
	// array control
	output logic [1:0] o_array_op,
	output logic [5:0] o_erase_mask,
	output logic o_busy
);
	typedef struct packed {
		fec_state_e state;
		logic bulk;
		logic in_erase;
		logic [`FEC_NSECT-1:0] mask;
		logic toggle;
		logic err;
		logic [7:0] rdata;
		logic rd_vld;
		fec_op_e op;
		logic tmr_load;
		logic [`FEC_TMR_W-1:0] tmr_len;
		logic busy;
		logic [`FEC_SETTLE_CNT_W-1:0] susp_cnt;
	} fec_core_s;
	fec_core_s s_r;
	fec_core_s s_nxt;
	fec_if #(.TW(`FEC_TMR_W), .NS(`FEC_NSECT)) cif();
	logic [`FEC_NSECT-1:0] sel;
	logic wr;
	logic [7:0] status;
	logic status_mode;
	assign sel = {i_secondary_sector_selects, i_main_sector_selects};
	assign wr = i_wr_stb && (|sel);
	assign cif.prot_in = {i_secondary_prot, i_main_prot};
	assign cif.lock_in = i_security_lock;
	assign cif.tmr_load = s_r.tmr_load;
	assign cif.tmr_len = s_r.tmr_len;
	fec_timer #(.TW(`FEC_TMR_W)) u_timer (
		.i_clk_sys(i_clk_sys),
		.i_arst_n(i_arst_n),
		.tif(cif.tmr)
	);
	fec_prot u_prot (
		.i_clk_sys(i_clk_sys),
		.i_arst_n(i_arst_n),
		.pif(cif.prot)
	);
	// status byte while an operation is in flight
	always_comb
	begin
		status = 8'h00;
		status[`FEC_BIT_POLL] = 1'b0;
		status[`FEC_BIT_TOGGLE] = s_r.toggle;
		status[`FEC_BIT_ERR] = s_r.err;
		status[`FEC_BIT_WINDOW] = (s_r.state != ST_COLLECT);
		case (s_r.state)
			ST_COLLECT, ST_PRE_ZERO, ST_ERASE, ST_SUSP_WAIT, ST_ERR: status_mode = 1'b1;
			default: status_mode = 1'b0;
		endcase
	end
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.tmr_load = 1'b0;
		s_nxt.rd_vld = 1'b0;
		if (i_rd_stb)
		begin
			s_nxt.rd_vld = 1'b1;
			if (i_control_io_space && i_addr[7:0] == `FEC_OFF_PROT)
				s_nxt.rdata = cif.prot_main_reg;
			else if (i_control_io_space && i_addr[7:0] == `FEC_OFF_PROT2)
				s_nxt.rdata = cif.prot_sec_reg;
			else if (status_mode && |sel)
			begin
				s_nxt.rdata = status;
				// error state holds still so two reads match
				if (s_r.state != ST_ERR)
					s_nxt.toggle = ~s_r.toggle;
			end
			else
				// suspended erasing sector reads whatever the array holds
				s_nxt.rdata = i_array_rdata;
		end
		// settle count saturates; only the suspend timing checks read it
		if (s_r.state != ST_SUSP_WAIT)
			s_nxt.susp_cnt = '0;
		else if (!(&s_r.susp_cnt))
			s_nxt.susp_cnt = s_r.susp_cnt + 1'b1;
		case (s_r.state)
			ST_IDLE:
				if (wr && i_wdata == `FEC_CMD_UNLOCK1 && i_addr == `FEC_ADDR_UNLOCK1)
					s_nxt.state = ST_UNL1;
			ST_UNL1:
				if (wr && i_wdata == `FEC_CMD_UNLOCK2 && i_addr == `FEC_ADDR_UNLOCK2)
					s_nxt.state = ST_UNL2;
				else if (wr)
					s_nxt.state = ST_IDLE;
			ST_UNL2:
				if (wr && i_wdata == `FEC_CMD_SETUP)
					s_nxt.state = ST_SETUP;
				else if (wr)
					s_nxt.state = ST_IDLE;
			ST_SETUP:
				if (wr && i_wdata == `FEC_CMD_UNLOCK1 && i_addr == `FEC_ADDR_UNLOCK1)
					s_nxt.state = ST_UNL3;
				else if (wr)
					s_nxt.state = ST_IDLE;
			ST_UNL3:
				if (wr && i_wdata == `FEC_CMD_UNLOCK2 && i_addr == `FEC_ADDR_UNLOCK2)
					s_nxt.state = ST_UNL4;
				else if (wr)
					s_nxt.state = ST_IDLE;
			ST_UNL4:
				if (wr && i_wdata == `FEC_CMD_BULK)
				begin
					// protected sectors drop out; nothing left means no erase
					s_nxt.mask = ~cif.prot_mask;
					s_nxt.bulk = 1'b1;
					s_nxt.in_erase = 1'b0;
					s_nxt.state = (&cif.prot_mask) ? ST_IDLE : ST_PRE_ZERO;
					s_nxt.op = (&cif.prot_mask) ? OP_NONE : OP_ZERO;
				end
				else if (wr && i_wdata == `FEC_CMD_SECTOR)
				begin
					s_nxt.mask = sel & ~cif.prot_mask;
					s_nxt.bulk = 1'b0;
					s_nxt.in_erase = 1'b0;
					s_nxt.state = ST_COLLECT;
					s_nxt.tmr_load = 1'b1;
					s_nxt.tmr_len = `FEC_TMR_W'(COLLECT_CYC);
				end
				else if (wr)
					s_nxt.state = ST_IDLE;
			ST_COLLECT:
				if (wr && i_wdata == `FEC_CMD_SECTOR)
				begin
					s_nxt.mask = s_r.mask | (sel & ~cif.prot_mask);
					s_nxt.tmr_load = 1'b1;
					s_nxt.tmr_len = `FEC_TMR_W'(COLLECT_CYC);
				end
				else if (wr && i_wdata == `FEC_CMD_SUSPEND)
				begin
					// window closes here, later sector codes cannot join
					s_nxt.state = ST_SUSP_WAIT;
					s_nxt.tmr_load = 1'b1;
					s_nxt.tmr_len = `FEC_TMR_W'(SETTLE_CYC);
				end
				else if (wr)
				begin
					s_nxt.state = ST_IDLE;
					s_nxt.mask = '0;
				end
				else if (cif.tmr_expired && !s_r.tmr_load)
				begin
					s_nxt.state = (|s_r.mask) ? ST_PRE_ZERO : ST_IDLE;
					s_nxt.op = (|s_r.mask) ? OP_ZERO : OP_NONE;
				end
			ST_PRE_ZERO, ST_ERASE:
				if (i_array_fail)
				begin
					s_nxt.state = ST_ERR;
					s_nxt.err = 1'b1;
					s_nxt.op = OP_NONE;
				end
				else if (!s_r.bulk && wr && i_wdata == `FEC_CMD_RESET)
				begin
					s_nxt.state = ST_IDLE;
					s_nxt.op = OP_NONE;
					s_nxt.mask = '0;
				end
				else if (!s_r.bulk && wr && i_wdata == `FEC_CMD_SUSPEND)
				begin
					s_nxt.state = ST_SUSP_WAIT;
					s_nxt.in_erase = (s_r.state == ST_ERASE);
					s_nxt.op = OP_NONE;
					s_nxt.tmr_load = 1'b1;
					s_nxt.tmr_len = `FEC_TMR_W'(SETTLE_CYC);
				end
				else if (i_array_done && s_r.state == ST_PRE_ZERO)
				begin
					s_nxt.state = ST_ERASE;
					s_nxt.op = OP_ERASE;
				end
				else if (i_array_done)
				begin
					s_nxt.state = ST_IDLE;
					s_nxt.op = OP_NONE;
					s_nxt.mask = '0;
					s_nxt.bulk = 1'b0;
				end
				// bulk erase takes no write at all until done
			ST_SUSP_WAIT:
				if (cif.tmr_expired && !s_r.tmr_load)
					s_nxt.state = ST_SUSPENDED;
			ST_SUSPENDED:
				if (wr && i_wdata == `FEC_CMD_RESUME)
				begin
					s_nxt.state = s_r.in_erase ? ST_ERASE : ST_PRE_ZERO;
					s_nxt.op = s_r.in_erase ? OP_ERASE : OP_ZERO;
				end
				else if (wr && i_wdata == `FEC_CMD_RESET)
				begin
					// interrupted sector is left half erased
					s_nxt.state = ST_IDLE;
					s_nxt.mask = '0;
				end
				// programming and other codes ignored here
			ST_ERR:
				if (wr && i_wdata == `FEC_CMD_RESET)
				begin
					s_nxt.state = ST_IDLE;
					s_nxt.err = 1'b0;
					s_nxt.mask = '0;
					s_nxt.bulk = 1'b0;
				end
			default:
				s_nxt.state = ST_IDLE;
		endcase
		s_nxt.busy = (s_nxt.state == ST_COLLECT) || (s_nxt.state == ST_PRE_ZERO)
			|| (s_nxt.state == ST_ERASE) || (s_nxt.state == ST_SUSP_WAIT)
			|| (s_nxt.state == ST_ERR);
	end
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			s_r <= '0;
			s_r.state <= ST_IDLE;
			s_r.op <= OP_NONE;
		end
		else
			s_r <= s_nxt;
	end
	assign o_rdata = s_r.rdata;
	assign o_rd_vld = s_r.rd_vld;
	assign o_array_op = s_r.op;
	assign o_erase_mask = s_r.mask;
	assign o_busy = s_r.busy;
	localparam int SETTLE_MAX = `FEC_SETTLE_MAX_CYC;
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_arst_n);
	sequence s_bulk_run;
		s_r.bulk && (s_r.state == ST_PRE_ZERO || s_r.state == ST_ERASE) && !i_array_done
			&& !i_array_fail;
	endsequence
	sequence s_susp_entry;
		s_r.state != ST_SUSP_WAIT ##1 s_r.state == ST_SUSP_WAIT;
	endsequence
	a_bulk_ignores_cmds: assert property (s_bulk_run |=> $stable(s_r.state))
		else $error("bulk erase changed state on a write");
	a_fail_sets_err: assert property (((s_r.state == ST_PRE_ZERO || s_r.state == ST_ERASE)
		&& i_array_fail)
		|=> s_r.err && s_r.state == ST_ERR && s_r.op == OP_NONE)
		else $error("erase failure did not raise error bit");
	a_zero_before_erase: assert property ($rose(s_r.state == ST_ERASE)
		|-> $past(s_r.state) == ST_PRE_ZERO || $past(s_r.state) == ST_SUSPENDED)
		else $error("erase phase entered without zero phase");
	a_window_reads_low: assert property ((s_r.state == ST_COLLECT && i_rd_stb && |sel
		&& !i_control_io_space) |=> o_rd_vld && !o_rdata[`FEC_BIT_WINDOW]
		&& !o_rdata[`FEC_BIT_POLL])
		else $error("window bit not low during collection");
	a_code_restarts: assert property ((s_r.state == ST_COLLECT && wr
		&& i_wdata == `FEC_CMD_SECTOR) |=> s_r.tmr_load ##1 !cif.tmr_expired)
		else $error("sector code did not restart timeout");
	a_collect_abort: assert property ((s_r.state == ST_COLLECT && wr
		&& i_wdata != `FEC_CMD_SECTOR && i_wdata != `FEC_CMD_SUSPEND)
		|=> s_r.state == ST_IDLE)
		else $error("foreign command did not abort collection");
	a_suspend_settles: assert property ((s_r.state == ST_SUSP_WAIT)
		|-> (s_r.susp_cnt < SETTLE_MAX))
		else $error("suspend did not settle in time");
	a_suspend_not_early: assert property ($rose(s_r.state == ST_SUSPENDED)
		|-> ($past(s_r.susp_cnt) >= SETTLE_CYC))
		else $error("suspend settled too early");
	a_suspend_stops_op: assert property (s_susp_entry |-> s_r.op == OP_NONE)
		else $error("array kept working after suspend");
	a_suspend_refuses: assert property ((s_r.state == ST_SUSPENDED && wr
		&& i_wdata != `FEC_CMD_RESUME && i_wdata != `FEC_CMD_RESET)
		|=> s_r.state == ST_SUSPENDED && s_r.op == OP_NONE)
		else $error("suspended state acted on a foreign command");
	a_erase_only_rst: assert property ((!s_r.bulk && s_r.state == ST_ERASE && wr
		&& !i_array_fail && !i_array_done && i_wdata != `FEC_CMD_RESET
		&& i_wdata != `FEC_CMD_SUSPEND) |=> s_r.state == ST_ERASE)
		else $error("running sector erase acted on a foreign command");
	a_toggle_inverts: assert property ((status_mode && s_r.state != ST_ERR && i_rd_stb
		&& |sel && !i_control_io_space) |=> s_r.toggle != $past(s_r.toggle))
		else $error("toggle bit did not invert on busy read");
endmodule

/* File: fec_params.svh */
`ifndef FEC_PARAMS_SVH
`define FEC_PARAMS_SVH
`define FEC_CMD_UNLOCK1 8'haa
`define FEC_CMD_UNLOCK2 8'h55
`define FEC_ADDR_UNLOCK1 12'h555
`define FEC_ADDR_UNLOCK2 12'haaa
`define FEC_CMD_SETUP 8'h80
`define FEC_CMD_BULK 8'h10
`define FEC_CMD_SECTOR 8'h30
`define FEC_CMD_RESUME 8'h30
`define FEC_CMD_SUSPEND 8'hb0
`define FEC_CMD_RESET 8'hf0
`define FEC_CLK_MHZ 125
`define FEC_COLLECT_NS 100000
`define FEC_SETTLE_MIN_NS 100
`define FEC_COLLECT_CYC ((`FEC_COLLECT_NS * `FEC_CLK_MHZ) / 1000)
`define FEC_SETTLE_CYC ((`FEC_SETTLE_MIN_NS * `FEC_CLK_MHZ + 999) / 1000)
`define FEC_SETTLE_MAX_NS 15000
`define FEC_SETTLE_MAX_CYC ((`FEC_SETTLE_MAX_NS * `FEC_CLK_MHZ) / 1000)
`define FEC_SETTLE_CNT_W 11
`define FEC_TMR_W 16
`define FEC_NSECT 6
`define FEC_NMAIN 4
`define FEC_BIT_POLL 7
`define FEC_BIT_TOGGLE 6
`define FEC_BIT_ERR 5
`define FEC_BIT_WINDOW 3
`define FEC_BIT_LOCK 7
`define FEC_OFF_PROT 8'hc0
`define FEC_OFF_PROT2 8'hc2
`endif

/* File: fec_pkg.sv */
package fec_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_UNL1 = 4'h1,
		ST_UNL2 = 4'h3,
		ST_SETUP = 4'h2,
		ST_UNL3 = 4'h6,
		ST_UNL4 = 4'h7,
		ST_COLLECT = 4'h5,
		ST_PRE_ZERO = 4'h4,
		ST_ERASE = 4'hc,
		ST_SUSP_WAIT = 4'hd,
		ST_SUSPENDED = 4'hf,
		ST_ERR = 4'he
	} fec_state_e;
	typedef enum logic [1:0] {
		OP_NONE = 2'h0,
		OP_ZERO = 2'h1,
		OP_ERASE = 2'h2
	} fec_op_e;
endpackage

/* File: fec_if.sv */
`timescale 1ns/10ps
interface fec_if #(parameter int TW = 16, parameter int NS = 6);
	logic tmr_load;
	logic [TW-1:0] tmr_len;
	logic tmr_expired;
	logic [NS-1:0] prot_in;
	logic lock_in;
	logic [NS-1:0] prot_mask;
	logic [7:0] prot_main_reg;
	logic [7:0] prot_sec_reg;
	modport core (output tmr_load, output tmr_len, input tmr_expired,
		input prot_mask, input prot_main_reg, input prot_sec_reg);
	modport tmr (input tmr_load, input tmr_len, output tmr_expired);
	modport prot (input prot_in, input lock_in, output prot_mask,
		output prot_main_reg, output prot_sec_reg);
endinterface

/* File: fec_timer.sv */
`timescale 1ns/10ps
module fec_timer
	import fec_pkg::*;
#(
	parameter int TW = 16
)(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	// control
	fec_if.tmr tif
);
	typedef struct packed {
		logic [TW-1:0] cnt;
		logic run;
		logic expired;
	} fec_tmr_s;
	fec_tmr_s s_r;
	fec_tmr_s s_nxt;
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.expired = 1'b0;
		if (tif.tmr_load)
		begin
			// full reload; a stale expiry is dropped
			s_nxt.cnt = tif.tmr_len;
			s_nxt.run = 1'b1;
		end
		else if (s_r.run)
		begin
			if (s_r.cnt <= TW'(1))
			begin
				s_nxt.run = 1'b0;
				s_nxt.expired = 1'b1;
				s_nxt.cnt = '0;
			end
			else
				s_nxt.cnt = s_r.cnt - TW'(1);
		end
	end
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
	assign tif.tmr_expired = s_r.expired;
endmodule

/* File: fec_prot.sv */
`timescale 1ns/10ps
`include "fec_params.svh"
module fec_prot
	import fec_pkg::*;
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	// protection view
	fec_if.prot pif
);
	typedef struct packed {
		logic [`FEC_NSECT-1:0] prot;
		logic lock;
	} fec_prot_s;
	fec_prot_s s_r;
	fec_prot_s s_nxt;
	always_comb
	begin
		s_nxt.prot = pif.prot_in;
		s_nxt.lock = pif.lock_in;
	end
	// protected until first sample, so no erase slips through at reset
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			s_r <= '1;
		else
			s_r <= s_nxt;
	end
	assign pif.prot_mask = s_r.prot;
	// unused upper bits read zero
	assign pif.prot_main_reg = {4'h0, s_r.prot[`FEC_NMAIN-1:0]};
	assign pif.prot_sec_reg = {s_r.lock, 5'h00, s_r.prot[`FEC_NSECT-1:`FEC_NMAIN]};
endmodule

/* File: fec_array_model.sv */
`timescale 1ns/10ps
module fec_array_model
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	// phase request and pacing
	input wire logic [1:0] i_op,
	input wire logic [7:0] i_dly,
	input wire logic i_fail_req,
	// phase result
	output logic o_done,
	output logic o_fail
);
	logic [7:0] cnt_r;
	logic [1:0] op_r;
	// restart on every op change so a resumed phase runs its full time
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			cnt_r <= 8'h00;
			op_r <= 2'h0;
			o_done <= 1'b0;
			o_fail <= 1'b0;
		end
		else
		begin
			op_r <= i_op;
			o_done <= 1'b0;
			o_fail <= 1'b0;
			if (i_op != op_r || i_op == 2'h0)
				cnt_r <= 8'h00;
			else if (cnt_r <= i_dly)
				cnt_r <= cnt_r + 8'h01;
			// pulse only while a phase is requested
			if (i_op != 2'h0 && i_op == op_r && cnt_r == i_dly)
			begin
				o_done <= !i_fail_req;
				o_fail <= i_fail_req;
			end
		end
	end
endmodule

/* File: fec_erase_ctl_test.sv */
`timescale 1ns/10ps
`include "fec_params.svh"
module fec_erase_ctl_test;
	localparam int CC = 20;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic cio = 1'b0;
	logic lock = 1'b0;
	logic freq = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [7:0] wd = 8'h00;
	logic [7:0] ard = 8'h00;
	logic [7:0] dly = 8'h04;
	logic [3:0] msel = 4'h0;
	logic [3:0] mprot = 4'h0;
	logic [1:0] ssel = 2'h0;
	logic [1:0] sprot = 2'h0;
	logic [7:0] rdata;
	logic [1:0] op;
	logic [5:0] emask;
	logic vld, busy, done, fail;
	logic [31:0] r;
	logic [16:0] ent;
	logic [7:0] last_rd = 8'h00;
	logic [16:0] exp_q[$];
	int err_count = 0;
	int total_checks = 0;

	always #4 clk = ~clk;

	fec_erase_ctl #(.COLLECT_CYC(CC)) u_dut (.i_clk_sys(clk), .i_arst_n(rst_n),
		.i_wr_stb(wr), .i_rd_stb(rd), .i_addr(addr), .i_wdata(wd),
		.i_main_sector_selects(msel), .i_secondary_sector_selects(ssel),
		.i_control_io_space(cio), .i_array_rdata(ard), .i_array_done(done),
		.i_array_fail(fail), .i_main_prot(mprot), .i_secondary_prot(sprot),
		.i_security_lock(lock), .o_rdata(rdata), .o_rd_vld(vld),
		.o_array_op(op), .o_erase_mask(emask), .o_busy(busy));

	fec_array_model u_arr (.i_clk_sys(clk), .i_arst_n(rst_n), .i_op(op),
		.i_dly(dly), .i_fail_req(freq), .o_done(done), .o_fail(fail));

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr_b(input logic [11:0] a, input logic [7:0] d, input logic [5:0] s);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wd <= d;
		{ssel, msel} <= s;
		@(posedge clk);
		wr <= 1'b0;
		{ssel, msel} <= 6'h00;
	endtask

	task automatic rd_b(input logic [11:0] a, input logic [5:0] s, input logic c,
		input logic [7:0] e, input logic [7:0] m, input logic t);
		@(posedge clk);
		exp_q.push_back({t, m, e});
		rd <= 1'b1;
		addr <= a;
		cio <= c;
		{ssel, msel} <= s;
		@(posedge clk);
		rd <= 1'b0;
		cio <= 1'b0;
		{ssel, msel} <= 6'h00;
	endtask

	task automatic unl(input logic [5:0] s);
		wr_b(`FEC_ADDR_UNLOCK1, `FEC_CMD_UNLOCK1, s);
		wr_b(`FEC_ADDR_UNLOCK2, `FEC_CMD_UNLOCK2, s);
	endtask

	task automatic cmd6(input logic [7:0] last, input logic [5:0] s);
		unl(s);
		wr_b(`FEC_ADDR_UNLOCK1, `FEC_CMD_SETUP, s);
		unl(s);
		wr_b(12'h000, last, s);
	endtask

	task automatic wait_op(input logic [1:0] v, input int n);
		for (int i = 0; i < n && op !== v; i++)
			@(posedge clk);
		#1;
		if (op !== v)
		begin
			chk({6'h0, op}, {6'h0, v});
			wrap_up();
		end
	endtask

	// read answers arrive in order, so the oldest note matches
	always @(posedge clk)
		if (vld === 1'b1)
		begin
			ent = exp_q.pop_front();
			if (ent[16])
				chk({7'h0, rdata[6] ^ last_rd[6]}, 8'h01);
			chk(rdata & ent[15:8], ent[7:0] & ent[15:8]);
			last_rd = rdata;
		end

	initial
	begin
		r = $urandom(32'hf3df);
		r = $urandom();
		mprot = 4'h8 | (r[3:0] & 4'h2);
		sprot = r[5:4];
		lock = r[6];
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk({busy, op, emask[4:0]}, 8'h00);
		rd_b({4'h0, `FEC_OFF_PROT}, 6'h00, 1'b1, {4'h0, mprot}, 8'h0f, 1'b0);
		rd_b({4'h0, `FEC_OFF_PROT2}, 6'h00, 1'b1, {lock, 5'h0, sprot}, 8'h83, 1'b0);
		$display("test protect done");
		dly <= 8'd40;
		cmd6(`FEC_CMD_SECTOR, 6'h01);
		rd_b(12'h010, 6'h01, 1'b0, 8'h00, 8'hb8, 1'b0);
		repeat (10) @(posedge clk);
		wr_b(12'h000, `FEC_CMD_SECTOR, 6'h04);
		wr_b(12'h000, `FEC_CMD_SECTOR, 6'h08);
		repeat (15) @(posedge clk);
		#1 chk({6'h0, op}, 8'h00);
		wait_op(2'h1, 20);
		chk({2'h0, emask}, 8'h05);
		rd_b(12'h010, 6'h01, 1'b0, 8'h08, 8'hb8, 1'b0);
		rd_b(12'h010, 6'h01, 1'b0, 8'h08, 8'hb8, 1'b1);
		wait_op(2'h2, 60);
		wr_b(12'h000, `FEC_CMD_SETUP, 6'h01);
		#1 chk({6'h0, op}, 8'h02);
		wr_b(12'h123, `FEC_CMD_SUSPEND, 6'h01);
		#1 chk({6'h0, op}, 8'h00);
		repeat (20) @(posedge clk);
		#1 chk({7'h0, busy}, 8'h00);
		r = $urandom();
		ard <= r[7:0];
		rd_b(12'h020, 6'h02, 1'b0, r[7:0], 8'hff, 1'b0);
		wr_b(12'h000, `FEC_CMD_SETUP, 6'h01);
		wr_b(12'h000, `FEC_CMD_RESUME, 6'h01);
		#1 chk({6'h0, op}, 8'h02);
		wait_op(2'h0, 60);
		chk({1'b0, busy, emask}, 8'h00);
		$display("test sector done");
		unl(6'h01);
		wr_b(`FEC_ADDR_UNLOCK1, `FEC_CMD_SETUP, 6'h01);
		wr_b(`FEC_ADDR_UNLOCK1, 8'h5a, 6'h01);
		wr_b(`FEC_ADDR_UNLOCK2, `FEC_CMD_UNLOCK2, 6'h01);
		wr_b(12'h000, `FEC_CMD_BULK, 6'h01);
		#1 chk({5'h0, busy, op}, 8'h00);
		cmd6(`FEC_CMD_SECTOR, 6'h01);
		wr_b(12'h000, `FEC_CMD_SETUP, 6'h01);
		repeat (CC + 4) @(posedge clk);
		#1 chk({5'h0, busy, op}, 8'h00);
		cmd6(`FEC_CMD_SECTOR, 6'h01);
		wr_b(12'h000, `FEC_CMD_SUSPEND, 6'h01);
		repeat (20) @(posedge clk);
		wr_b(12'h000, `FEC_CMD_SECTOR, 6'h04);
		wait_op(2'h1, CC + 10);
		chk({2'h0, emask}, 8'h01);
		wr_b(12'h000, `FEC_CMD_RESET, 6'h01);
		#1 chk({5'h0, busy, op}, 8'h00);
		$display("test abort done");
		dly <= 8'd12;
		freq <= 1'b1;
		cmd6(`FEC_CMD_BULK, 6'h01);
		#1 chk({2'h0, emask}, {2'h0, ~{sprot, mprot}});
		wr_b(12'h000, `FEC_CMD_RESET, 6'h01);
		#1 chk({6'h0, op}, 8'h01);
		repeat (20) @(posedge clk);
		rd_b(12'h010, 6'h01, 1'b0, 8'h20, 8'ha0, 1'b0);
		freq <= 1'b0;
		unl(6'h01);
		wr_b(12'h000, `FEC_CMD_RESET, 6'h01);
		#1 chk({6'h0, busy, 1'b0}, 8'h00);
		rd_b(12'h010, 6'h01, 1'b0, r[7:0], 8'hff, 1'b0);
		$display("test bulk done");
		repeat (4) @(posedge clk);
		chk(8'(exp_q.size()), 8'h00);
		wrap_up();
	end
endmodule
